// ==== verilog/asp_pkg.sv ====
// Constants, types and register map of the asynchronous serial port.
// Assumes one 125 MHz core clock and an APB master with 32-bit data.
package asp_pkg;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam int          ASP_ADDR_W     = 8;
  localparam logic [7:0]  ASP_OFF_CTRL   = 8'h00;
  localparam logic [7:0]  ASP_OFF_DATA   = 8'h04;
  localparam logic [7:0]  ASP_OFF_RELOAD = 8'h08;
  localparam logic [7:0]  ASP_OFF_TCFG   = 8'h0C;
  localparam logic [7:0]  ASP_OFF_TLOW   = 8'h10;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0]  ASP_CTRL_RST   = 8'h40;
  localparam logic [7:0]  ASP_RELOAD_RST = 8'h00;
  localparam logic [7:0]  ASP_RXBUF_RST  = 8'h00;

  // ***************************************************************
  // Timing and frame counts
  // ***************************************************************
  localparam int          ASP_TIMER_SPAN = 256;
  localparam int          ASP_PRE_DIV4   = 4;
  localparam int          ASP_PRE_DIV12  = 12;
  localparam int          ASP_PRE_DIV48  = 48;
  localparam logic [2:0]  ASP_OSC_LAST   = 3'h7;
  localparam logic [5:0]  ASP_PRE_LAST   = 6'h2F;
  localparam logic [2:0]  ASP_RX_LAST    = 3'h7;
  localparam logic [3:0]  ASP_TX_N8      = 4'h9;
  localparam logic [3:0]  ASP_TX_N9      = 4'hA;

  // ***************************************************************
  // Types
  // ***************************************************************
  typedef enum logic [2:0] {
    SRC_CORE    = 3'h0,
    SRC_DIV4    = 3'h1,
    SRC_DIV12   = 3'h2,
    SRC_DIV48   = 3'h3,
    SRC_EXTOSC8 = 3'h4,
    SRC_EXTIN   = 3'h5
  } asp_src_t;

  typedef struct packed {
    logic frame_width_select;
    logic unused;
    logic multiproc_filter_enable;
    logic receive_enable_bit;
    logic transmit_extra_bit;
    logic received_extra_bit;
    logic transmit_done_flag;
    logic receive_done_flag;
  } asp_ctrl_t;

  typedef struct packed {
    logic     irq_enable;
    asp_src_t source;
    logic     run;
  } asp_tcfg_t;

  localparam asp_tcfg_t   ASP_TCFG_RST   = '{1'b0, SRC_CORE, 1'b0};

  typedef enum logic [2:0] {
    RX_IDLE  = 3'h0,
    RX_START = 3'h1,
    RX_DATA  = 3'h2,
    RX_NINTH = 3'h3,
    RX_STOP  = 3'h4
  } asp_rx_state_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'h0,
    TX_LOAD = 2'h1,
    TX_BITS = 2'h2,
    TX_STOP = 2'h3
  } asp_tx_state_t;

endpackage

// ==== verilog/asp_reload_timer.sv ====
// Eight-bit auto-reload counter with a divide-by-two overflow stage.
// Assumes tick_in is a one-cycle enable on the core clock.
`timescale 1ns/1ps
module asp_reload_timer
  import asp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       srst_in,
  // Control
  input  wire logic       run_in,
  input  wire logic       tick_in,
  input  wire logic       force_in,
  input  wire logic [7:0] reload_in,
  // Results
  output logic      [7:0] count_out,
  output logic            ovf_out,
  output logic            div2_out
);

  logic phase_r;

  always_ff @(posedge clk_in) begin
    if (srst_in || force_in) begin
      count_out <= srst_in ? ASP_RELOAD_RST : reload_in;
      phase_r   <= 1'b0;
      ovf_out   <= 1'b0;
      div2_out  <= 1'b0;
    end else if (run_in && tick_in) begin
      if (count_out == 8'hFF) begin
        count_out <= reload_in;
        phase_r   <= ~phase_r;
        ovf_out   <= 1'b1;
        div2_out  <= phase_r;
      end else begin
        count_out <= count_out + 8'h01;
        ovf_out   <= 1'b0;
        div2_out  <= 1'b0;
      end
    end else begin
      ovf_out  <= 1'b0;
      div2_out <= 1'b0;
    end
  end

endmodule

// ==== verilog/asp_serial_port.sv ====
// Asynchronous serial port with its bit-rate timer and APB registers.
// Assumes pins arrive asynchronously and an APB master on clk_in.
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module asp_serial_port
  import asp_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_in,
  input  wire logic                  srst_in,
  // APB slave
  input  wire logic                  apb_psel_in,
  input  wire logic                  apb_penable_in,
  input  wire logic                  apb_pwrite_in,
  input  wire logic [ASP_ADDR_W-1:0] apb_paddr_in,
  input  wire logic [31:0]           apb_pwdata_in,
  output logic      [31:0]           apb_prdata_out,
  output logic                       apb_pready_out,
  output logic                       apb_pslverr_out,
  // Serial pins
  input  wire logic                  serial_receive_pin_in,
  output logic                       serial_transmit_pin_out,
  // Timer clock pins
  input  wire logic                  ext_osc_in,
  input  wire logic                  timer_external_input_in,
  // Interrupt
  output logic                       irq_out
);

  // ***************************************************************
  // Declarations
  // ***************************************************************
  asp_ctrl_t     ctrl_r;
  asp_tcfg_t     tcfg_r;
  logic [7:0]    reload_r;
  logic [7:0]    rx_buf_r;
  logic          apb_access;
  logic          apb_take;
  logic          wr_ctrl;
  logic          wr_data;
  logic          wr_reload;
  logic          wr_tcfg;
  logic [5:0]    pre_cnt_r;
  logic [2:0]    osc_sync_r;
  logic [2:0]    osc_cnt_r;
  logic          osc8_tick;
  logic [2:0]    tin_sync_r;
  logic          tin_tick;
  logic          timer_tick;
  logic [7:0]    tx_count;
  logic          tx_bit_tick;
  logic          rx_ovf;
  logic          rx_div2;
  logic          rx_tick;
  logic [2:0]    rx_sync_r;
  logic          rx_line;
  logic          rx_fall;
  logic          rx_start;
  asp_rx_state_t rx_state_r;
  logic [2:0]    rx_cnt_r;
  logic [7:0]    rx_shift_r;
  logic          rx_ninth_r;
  logic          rx_end;
  logic          rx_extra;
  logic          rx_accept;
  asp_tx_state_t tx_state_r;
  logic [9:0]    tx_frame_r;
  logic [3:0]    tx_cnt_r;
  logic [3:0]    tx_nbits;
  logic          tx_start;
  logic          tx_done_evt;

  // ***************************************************************
  // Helpers
  // ***************************************************************
  function automatic logic reg_hit(input logic [ASP_ADDR_W-1:0] a,
                                   input logic [ASP_ADDR_W-1:0] off);
    return a == off;
  endfunction

  function automatic logic div_last(input logic [5:0] c, input int d);
    return (int'(c) % d) == (d - 1);
  endfunction

  function automatic logic mapped(input logic [ASP_ADDR_W-1:0] a);
    return a inside {ASP_OFF_CTRL, ASP_OFF_DATA, ASP_OFF_RELOAD, ASP_OFF_TCFG, ASP_OFF_TLOW};
  endfunction

  // ***************************************************************
  // APB slave
  // ***************************************************************
  // One wait state: pready rises in the second access cycle
  assign apb_access = apb_psel_in && apb_penable_in;
  assign apb_take   = apb_access && apb_pready_out;
  assign wr_ctrl    = apb_take && apb_pwrite_in && reg_hit(apb_paddr_in, ASP_OFF_CTRL);
  assign wr_data    = apb_take && apb_pwrite_in && reg_hit(apb_paddr_in, ASP_OFF_DATA);
  assign wr_reload  = apb_take && apb_pwrite_in && reg_hit(apb_paddr_in, ASP_OFF_RELOAD);
  assign wr_tcfg    = apb_take && apb_pwrite_in && reg_hit(apb_paddr_in, ASP_OFF_TCFG);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      apb_pready_out  <= 1'b0;
      apb_pslverr_out <= 1'b0;
    end else begin
      apb_pready_out  <= apb_access && !apb_pready_out;
      apb_pslverr_out <= apb_access && !apb_pready_out && !mapped(apb_paddr_in);
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      apb_prdata_out <= 32'h0000_0000;
    end else if (apb_access && !apb_pready_out && !apb_pwrite_in) begin
      unique case (apb_paddr_in)
        ASP_OFF_CTRL:   apb_prdata_out <= {24'h000000, ctrl_r};
        ASP_OFF_DATA:   apb_prdata_out <= {24'h000000, rx_buf_r};
        ASP_OFF_RELOAD: apb_prdata_out <= {24'h000000, reload_r};
        ASP_OFF_TCFG:   apb_prdata_out <= {27'h0000000, tcfg_r};
        ASP_OFF_TLOW:   apb_prdata_out <= {24'h000000, tx_count};
        default:        apb_prdata_out <= 32'h0000_0000;
      endcase
    end
  end

  // ***************************************************************
  // Configuration registers
  // ***************************************************************
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      reload_r <= ASP_RELOAD_RST;
      tcfg_r   <= ASP_TCFG_RST;
    end else begin
      if (wr_reload) begin
        reload_r <= apb_pwdata_in[7:0];
      end
      if (wr_tcfg) begin
        tcfg_r <= apb_pwdata_in[4:0];
      end
    end
  end

  // Control register; hardware sets win over software writes
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ctrl_r <= ASP_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_r <= {apb_pwdata_in[7], ASP_CTRL_RST[6], apb_pwdata_in[5:0]};
      end
      if (tx_done_evt) begin
        ctrl_r.transmit_done_flag <= 1'b1;
      end
      if (rx_accept) begin
        ctrl_r.received_extra_bit <= rx_extra;
        ctrl_r.receive_done_flag  <= 1'b1;
      end
    end
  end

  // ***************************************************************
  // Timer clock sources
  // ***************************************************************
  always_ff @(posedge clk_in) begin
    if (srst_in || pre_cnt_r == ASP_PRE_LAST) begin
      pre_cnt_r <= 6'h00;
    end else begin
      pre_cnt_r <= pre_cnt_r + 6'h01;
    end
  end

  // Pin inputs: two flops, then edge detect
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      osc_sync_r <= 3'h0;
      tin_sync_r <= 3'h0;
      rx_sync_r  <= 3'h7;
    end else begin
      osc_sync_r <= {osc_sync_r[1:0], ext_osc_in};
      tin_sync_r <= {tin_sync_r[1:0], timer_external_input_in};
      rx_sync_r  <= {rx_sync_r[1:0], serial_receive_pin_in};
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      osc_cnt_r <= 3'h0;
    end else if (osc_sync_r[1] && !osc_sync_r[2]) begin
      osc_cnt_r <= osc_cnt_r + 3'h1;
    end
  end

  assign osc8_tick = osc_sync_r[1] && !osc_sync_r[2] && (osc_cnt_r == ASP_OSC_LAST);
  assign tin_tick  = tin_sync_r[1] && !tin_sync_r[2];

  always_comb begin
    unique case (tcfg_r.source)
      SRC_CORE:    timer_tick = 1'b1;
      SRC_DIV4:    timer_tick = div_last(pre_cnt_r, ASP_PRE_DIV4);
      SRC_DIV12:   timer_tick = div_last(pre_cnt_r, ASP_PRE_DIV12);
      SRC_DIV48:   timer_tick = div_last(pre_cnt_r, ASP_PRE_DIV48);
      SRC_EXTOSC8: timer_tick = osc8_tick;
      SRC_EXTIN:   timer_tick = tin_tick;
      default:     timer_tick = 1'b0;
    endcase
  end

  // ***************************************************************
  // Bit-rate timers
  // ***************************************************************
  asp_reload_timer u_tx_timer (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .run_in    (tcfg_r.run),
    .tick_in   (timer_tick),
    .force_in  (1'b0),
    .reload_in (reload_r),
    .count_out (tx_count),
    .ovf_out   (),
    .div2_out  (tx_bit_tick)
  );

  asp_reload_timer u_rx_timer (
    .clk_in    (clk_in),
    .srst_in   (srst_in),
    .run_in    (tcfg_r.run),
    .tick_in   (timer_tick),
    .force_in  (rx_start),
    .reload_in (reload_r),
    .count_out (),
    .ovf_out   (rx_ovf),
    .div2_out  (rx_div2)
  );

  // Odd overflows after reload fall mid-bit
  assign rx_tick = rx_ovf && !rx_div2;

  // ***************************************************************
  // Receiver
  // ***************************************************************
  assign rx_line  = rx_sync_r[1];
  assign rx_fall  = rx_sync_r[2] && !rx_sync_r[1];
  assign rx_start = rx_fall && (rx_state_r == RX_IDLE) &&
                    ctrl_r.receive_enable_bit;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rx_state_r <= RX_IDLE;
      rx_cnt_r   <= 3'h0;
      rx_shift_r <= 8'h00;
      rx_ninth_r <= 1'b0;
    end else begin
      unique case (rx_state_r)
        RX_IDLE: begin
          if (rx_start) begin
            rx_state_r <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_state_r <= rx_line ? RX_IDLE : RX_DATA;
            rx_cnt_r   <= 3'h0;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_shift_r <= {rx_line, rx_shift_r[7:1]};
            rx_cnt_r   <= rx_cnt_r + 3'h1;
            if (rx_cnt_r == ASP_RX_LAST) begin
              rx_state_r <= ctrl_r.frame_width_select ? RX_NINTH : RX_STOP;
            end
          end
        end
        RX_NINTH: begin
          if (rx_tick) begin
            rx_ninth_r <= rx_line;
            rx_state_r <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_state_r <= RX_IDLE;
          end
        end
        default: begin
          rx_state_r <= RX_IDLE;
        end
      endcase
    end
  end

  // Stop bit in 8-bit mode, ninth bit in 9-bit mode
  assign rx_end    = (rx_state_r == RX_STOP) && rx_tick;
  assign rx_extra  = ctrl_r.frame_width_select ? rx_ninth_r : rx_line;
  assign rx_accept = rx_end && !ctrl_r.receive_done_flag &&
                     (!ctrl_r.multiproc_filter_enable || rx_extra);

  // Separate holding buffer lets the next frame shift in
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      rx_buf_r <= ASP_RXBUF_RST;
    end else if (rx_accept) begin
      rx_buf_r <= rx_shift_r;
    end
  end

  // ***************************************************************
  // Transmitter
  // ***************************************************************
  assign tx_start    = wr_data && (tx_state_r == TX_IDLE);
  assign tx_nbits    = ctrl_r.frame_width_select ? ASP_TX_N9 : ASP_TX_N8;
  assign tx_done_evt = (tx_state_r == TX_BITS) && tx_bit_tick && (tx_cnt_r == tx_nbits);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      tx_state_r              <= TX_IDLE;
      tx_frame_r              <= 10'h3FF;
      tx_cnt_r                <= 4'h0;
      serial_transmit_pin_out <= 1'b1;
    end else begin
      unique case (tx_state_r)
        TX_IDLE: begin
          if (tx_start) begin
            tx_frame_r <= {ctrl_r.transmit_extra_bit, apb_pwdata_in[7:0], 1'b0};
            tx_state_r <= TX_LOAD;
          end
        end
        TX_LOAD: begin
          if (tx_bit_tick) begin
            serial_transmit_pin_out <= tx_frame_r[0];
            tx_frame_r              <= {1'b1, tx_frame_r[9:1]};
            tx_cnt_r                <= 4'h1;
            tx_state_r              <= TX_BITS;
          end
        end
        TX_BITS: begin
          if (tx_bit_tick) begin
            if (tx_cnt_r == tx_nbits) begin
              serial_transmit_pin_out <= 1'b1;
              tx_state_r              <= TX_STOP;
            end else begin
              serial_transmit_pin_out <= tx_frame_r[0];
              tx_frame_r              <= {1'b1, tx_frame_r[9:1]};
              tx_cnt_r                <= tx_cnt_r + 4'h1;
            end
          end
        end
        TX_STOP: begin
          if (tx_bit_tick) begin
            tx_state_r <= TX_IDLE;
          end
        end
      endcase
    end
  end

  // ***************************************************************
  // Interrupt request
  // ***************************************************************
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= tcfg_r.irq_enable &&
                 (ctrl_r.transmit_done_flag || ctrl_r.receive_done_flag);
    end
  end

endmodule

// ==== verif/asp_serial_port_assertions.sv ====
// Port-level checks for the serial port, bound to its top module.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/1ps
module asp_serial_port_assertions
  import asp_pkg::*;
(
  // Clock and reset
  input wire logic                  clk_in,
  input wire logic                  srst_in,
  // APB slave side
  input wire logic                  apb_psel_in,
  input wire logic                  apb_penable_in,
  input wire logic                  apb_pwrite_in,
  input wire logic [ASP_ADDR_W-1:0] apb_paddr_in,
  input wire logic [31:0]           apb_pwdata_in,
  input wire logic [31:0]           apb_prdata_out,
  input wire logic                  apb_pready_out,
  input wire logic                  apb_pslverr_out,
  // Pins
  input wire logic                  serial_receive_pin_in,
  input wire logic                  serial_transmit_pin_out,
  input wire logic                  ext_osc_in,
  input wire logic                  timer_external_input_in,
  input wire logic                  irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  logic mapped;
  logic acc_wr;
  assign mapped = apb_paddr_in inside {ASP_OFF_CTRL, ASP_OFF_DATA, ASP_OFF_RELOAD,
                                       ASP_OFF_TCFG, ASP_OFF_TLOW};
  assign acc_wr = apb_psel_in && apb_penable_in && apb_pwrite_in && apb_pready_out;

  property p_ready_pulse;
    apb_pready_out |=> !apb_pready_out;
  endproperty
  property p_ready_lat;
    apb_psel_in && !apb_penable_in ##1 apb_psel_in && apb_penable_in |=> apb_pready_out;
  endproperty
  property p_err_map;
    apb_pready_out |-> (apb_pslverr_out == !mapped);
  endproperty
  property p_err_zero;
    apb_pready_out && apb_pslverr_out && !apb_pwrite_in |-> apb_prdata_out == 32'h0;
  endproperty
  property p_ctrl_b6;
    apb_pready_out && !apb_pwrite_in && apb_paddr_in == ASP_OFF_CTRL |-> apb_prdata_out[6];
  endproperty
  property p_irq_clear;
    $fell(irq_out) |-> $past(acc_wr, 2);
  endproperty
  property p_tx_start;
    $fell(serial_transmit_pin_out) |=> !serial_transmit_pin_out;
  endproperty
  property p_tx_stop;
    $rose(serial_transmit_pin_out) |=> serial_transmit_pin_out;
  endproperty

  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  a_ready_lat: assert property (p_ready_lat) else $error("pready late");
  a_err_map: assert property (p_err_map) else $error("pslverr wrong for address");
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  a_ctrl_b6: assert property (p_ctrl_b6) else $error("control bit 6 not one");
  a_irq_clear: assert property (p_irq_clear) else $error("irq fell without write");
  a_tx_start: assert property (p_tx_start) else $error("start bit too short");
  a_tx_stop: assert property (p_tx_stop) else $error("high bit too short");

  c_data_wr: cover property (acc_wr && apb_paddr_in == ASP_OFF_DATA);
  c_irq: cover property ($rose(irq_out));
  c_err: cover property (apb_pready_out && apb_pslverr_out);
endmodule

bind asp_serial_port asp_serial_port_assertions u_chk (
  .clk_in(clk_in), .srst_in(srst_in), .apb_psel_in(apb_psel_in),
  .apb_penable_in(apb_penable_in), .apb_pwrite_in(apb_pwrite_in),
  .apb_paddr_in(apb_paddr_in), .apb_pwdata_in(apb_pwdata_in),
  .apb_prdata_out(apb_prdata_out), .apb_pready_out(apb_pready_out),
  .apb_pslverr_out(apb_pslverr_out), .serial_receive_pin_in(serial_receive_pin_in),
  .serial_transmit_pin_out(serial_transmit_pin_out), .ext_osc_in(ext_osc_in),
  .timer_external_input_in(timer_external_input_in), .irq_out(irq_out)
);

// ==== verif/asp_peer.sv ====
// Remote serial node: sends frames on the port's receive line and
// decodes frames from its transmit line. Assumes a fixed bit time.
`timescale 1ns/1ps
module asp_peer #(
  parameter int BIT_CYC = 16
) (
  // Clock
  input  wire logic clk_in,
  // Line
  input  wire logic tx_line_in,
  output logic      rx_line_out
);
  logic [8:0] got;
  logic       nine = 1'b0;
  int         rx_cnt = 0;
  int         cyc = 0;
  int         t0 = 0;
  int         low_len = 0;

  initial rx_line_out = 1'b1;

  task send_frame(input logic [7:0] d, input logic x9, input logic stp);
    logic [10:0] f;
    f = nine ? {stp, x9, d, 1'b0} : {1'b1, stp, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk_in);
      rx_line_out <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk_in);
    end
  endtask

  // Length of the latest low run
  always @(posedge clk_in) cyc++;
  always @(negedge tx_line_in) t0 = cyc;
  always @(posedge tx_line_in) low_len = cyc - t0;

  always begin
    @(negedge tx_line_in);
    got = 9'h0;
    repeat (BIT_CYC / 2) @(posedge clk_in);
    for (int i = 0; i < (nine ? 9 : 8); i++) begin
      repeat (BIT_CYC) @(posedge clk_in);
      got[i] = tx_line_in;
    end
    repeat (BIT_CYC) @(posedge clk_in);
    rx_cnt++;
  end
endmodule

// ==== verif/async_serial_port_with_baud_timer_tb_top.sv ====
// Testbench: APB register traffic plus serial frames to and from a peer.
// Assumes one 125 MHz clock and a 16-cycle bit time from reload 0xF8.
`timescale 1ns/1ps
module async_serial_port_with_baud_timer_tb_top;
  import asp_pkg::*;
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        apb_psel = 1'b0;
  logic        apb_penable = 1'b0;
  logic        apb_pwrite = 1'b0;
  logic [7:0]  apb_paddr = 8'h00;
  logic [31:0] apb_pwdata = 32'h0;
  logic [31:0] apb_prdata;
  logic        apb_pready;
  logic        apb_pslverr;
  logic        rx_line;
  logic        tx_line;
  logic        ext_osc = 1'b0;
  logic        ext_in = 1'b0;
  logic        irq;
  logic [31:0] rd;
  logic [31:0] v;
  logic        err;
  int          fails = 0;
  int          comparisons = 0;
  int          cycles = 0;

  asp_serial_port DUT (
    .clk_in(clk_in), .srst_in(srst_in), .apb_psel_in(apb_psel),
    .apb_penable_in(apb_penable), .apb_pwrite_in(apb_pwrite), .apb_paddr_in(apb_paddr),
    .apb_pwdata_in(apb_pwdata), .apb_prdata_out(apb_prdata), .apb_pready_out(apb_pready),
    .apb_pslverr_out(apb_pslverr), .serial_receive_pin_in(rx_line),
    .serial_transmit_pin_out(tx_line), .ext_osc_in(ext_osc),
    .timer_external_input_in(ext_in), .irq_out(irq)
  );
  asp_peer #(.BIT_CYC(16)) peer (.clk_in(clk_in), .tx_line_in(tx_line), .rx_line_out(rx_line));

  initial forever #4 clk_in = ~clk_in;

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    ext_osc <= cycles[1];
    ext_in <= (cycles % 10) < 5;
    if (cycles == 30000) begin
      fails++;
      end_sim();
    end
  end

  // ***************************************************************
  // Bus and compare tasks
  // ***************************************************************
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    apb_psel <= 1'b1;
    apb_penable <= 1'b0;
    apb_pwrite <= w;
    apb_paddr <= a;
    apb_pwdata <= d;
    @(posedge clk_in);
    apb_penable <= 1'b1;
    do @(posedge clk_in); while (apb_pready !== 1'b1);
    rd = apb_prdata;
    err = apb_pslverr;
    apb_psel <= 1'b0;
    apb_penable <= 1'b0;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ***************************************************************
  // Test sequence
  // ***************************************************************
  initial begin
    repeat (5) @(posedge clk_in);
    srst_in <= 1'b0;
    rchk(ASP_OFF_CTRL, 32'h40);
    rchk(ASP_OFF_RELOAD, 32'h0);
    rchk(ASP_OFF_TCFG, 32'h0);
    xfer(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int s = 0; s < 6; s++) begin
      xfer(1'b1, ASP_OFF_TCFG, 32'(2 * s + 1));
      xfer(1'b0, ASP_OFF_TLOW, 32'h0);
      v = rd;
      repeat (100) @(posedge clk_in);
      xfer(1'b0, ASP_OFF_TLOW, 32'h0);
      chk({31'h0, rd !== v}, 32'h1);
    end
    xfer(1'b1, ASP_OFF_RELOAD, 32'hF8);
    xfer(1'b1, ASP_OFF_TCFG, 32'h11);
    xfer(1'b1, ASP_OFF_DATA, 32'hA5);
    wait (peer.rx_cnt == 1);
    chk({23'h0, peer.got}, 32'hA5);
    chk(32'(peer.low_len), 32'h10);
    rchk(ASP_OFF_DATA, 32'h0);
    rchk(ASP_OFF_CTRL, 32'h42);
    chk({31'h0, irq}, 32'h1);
    xfer(1'b1, ASP_OFF_CTRL, 32'h10);
    peer.send_frame(8'h3C, 1'b0, 1'b1);
    rchk(ASP_OFF_DATA, 32'h3C);
    peer.send_frame(8'h99, 1'b0, 1'b1);
    rchk(ASP_OFF_DATA, 32'h3C);
    rchk(ASP_OFF_CTRL, 32'h55);
    xfer(1'b1, ASP_OFF_CTRL, 32'h10);
    rchk(ASP_OFF_CTRL, 32'h50);
    chk({31'h0, irq}, 32'h0);
    xfer(1'b1, ASP_OFF_CTRL, 32'h00);
    peer.send_frame(8'h77, 1'b0, 1'b1);
    rchk(ASP_OFF_CTRL, 32'h40);
    xfer(1'b1, ASP_OFF_CTRL, 32'h30);
    peer.send_frame(8'h11, 1'b0, 1'b0);
    rchk(ASP_OFF_CTRL, 32'h70);
    rchk(ASP_OFF_DATA, 32'h3C);
    xfer(1'b1, ASP_OFF_CTRL, 32'hB0);
    peer.nine = 1'b1;
    peer.send_frame(8'h22, 1'b0, 1'b1);
    rchk(ASP_OFF_CTRL, 32'hF0);
    peer.send_frame(8'h66, 1'b1, 1'b1);
    rchk(ASP_OFF_DATA, 32'h66);
    rchk(ASP_OFF_CTRL, 32'hF5);
    xfer(1'b1, ASP_OFF_CTRL, 32'h88);
    xfer(1'b1, ASP_OFF_DATA, 32'h5A);
    wait (peer.rx_cnt == 2);
    chk({23'h0, peer.got}, 32'h15A);
    rchk(ASP_OFF_CTRL, 32'hCA);
    end_sim();
  end
endmodule
